// ### hdl/rtcisp_defs.svh
// Constants of the real-time clock two-wire slave port: address, field positions, widths and bus rates.
`ifndef RTCISP_DEFS_SVH
`define RTCISP_DEFS_SVH

// Fixed 7-bit slave address, 1101000 in binary.
`define RTCISP_SLAVE_ADDR 7'h68

// Direction bit codes carried in bit 0 of the address byte.
`define RTCISP_DIR_WRITE 1'b0
`define RTCISP_DIR_READ 1'b1
`define RTCISP_DIR_BIT 0
`define RTCISP_ADDR_MSB 7
`define RTCISP_ADDR_LSB 1

// Byte layout: eight data bits, MSB first, counted 0 to 7.
`define RTCISP_DATA_W 8
`define RTCISP_DATA_MSB 7
`define RTCISP_BIT_LAST 3'h7

// Register pointer width and its reset value.
`define RTCISP_PTR_W 8
`define RTCISP_PTR_RST 8'h00

// Serial clock rates that the port must follow, in kHz.
`define RTCISP_STD_KHZ 100
`define RTCISP_FAST_KHZ 400

`endif

// ### hdl/rtcisp_pkg.sv
// Types shared by the real-time clock two-wire slave port.
package rtcisp_pkg;

  // Protocol engine states, Gray coded along idle, address, acknowledge, receive, transmit, master acknowledge.
  typedef enum logic [2:0] {
    RTCISP_ST_IDLE = 3'h0,
    RTCISP_ST_ADDR = 3'h1,
    RTCISP_ST_ACK = 3'h3,
    RTCISP_ST_RXD = 3'h2,
    RTCISP_ST_TXD = 3'h6,
    RTCISP_ST_MACK = 3'h7,
    RTCISP_ST_IGN = 3'h5
  } rtcisp_state_t;

endpackage : rtcisp_pkg

// ### hdl/rtcisp_mem_if.sv
// Interface between the protocol engine and the register byte store.
`timescale 1ns/1ps
interface rtcisp_mem_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  // The engine writes and addresses; the store answers with registered read data.
  modport eng (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : rtcisp_mem_if

// ### hdl/rtcisp_regmem.sv
// Register byte store of the slave port, one write port and a registered read port.
`timescale 1ns/1ps
module rtcisp_regmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk,
  rtcisp_mem_if.mem port
);
  logic [DW-1:0] store_q [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  // Write on the strobe; read data always comes from a register one cycle after the address.
  always_ff @(posedge clk) begin
    if (port.we) begin
      store_q[port.waddr] <= port.wdata;
    end
    rdata_q <= store_q[port.raddr];
  end

  assign port.rdata = rdata_q;
endmodule : rtcisp_regmem

// ### hdl/rtcisp_top.sv
// Two-wire serial slave port of a real-time clock: conditions, address match, pointer, register reads and writes.
// Rules of the two-wire bus that this block is written to
// [R1] Slave only, follows standard and fast clocks.
// [R2] Open-drain lines: pull low or release only.
// [R3] Master starts transfers only on idle bus.
// [R4] Data changes during clock high are conditions.
// [R5] Falling data with clock high is start.
// [R6] Rising data with clock high is stop.
// [R7] Transmitter changes data only while clock low.
// [R8] Whole bytes, MSB first, ninth acknowledge bit.
// [R9] Acknowledger holds data low through ninth pulse.
// [R10] After master not-acknowledge, device releases data.
// [R11] Master acknowledges all read bytes but last.
// [R12] Master makes clocks and conditions; clock never driven.
// [R13] Repeated start ends and restarts a transfer.
// [R14] First byte is address; acknowledge only on match.
// [R15] Direction zero writes, direction one reads.
// [R16] First written byte loads the register pointer.
// [R17] Later written bytes stored, acknowledged, pointer increments.
// [R18] Read sends register bytes from the pointer.
// [R19] Pointer keeps its value between transfers.
// [R20] Reads continue until master not-acknowledge ends them.
// [R21] Address mismatch: release data, ignore until condition.
`timescale 1ns/1ps
`include "rtcisp_defs.svh"
module rtcisp_top import rtcisp_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = `RTCISP_SLAVE_ADDR,
  parameter int AW = `RTCISP_PTR_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic bus_clk,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic reg_wr_valid,
  output logic [AW-1:0] reg_wr_addr,
  output logic [`RTCISP_DATA_W-1:0] reg_wr_data,
  output logic bus_active
);

  localparam int DW = `RTCISP_DATA_W;

  // ---------------- Link domain: reset, pin synchronisers and condition detection ----------------

  logic rst_m_q;
  logic lrst_q;
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;

  // The system reset reaches the link logic through two flip-flops of its own clock.
  always_ff @(posedge bus_clk) begin
    rst_m_q <= srst;
    lrst_q <= rst_m_q;
  end

  // Both pins pass two flip-flops; a third stage keeps the previous sample for edge detection.
  always_ff @(posedge bus_clk) begin
    scl_m_q <= scl_i;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_i;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end

  // Clock edges and bus conditions, oversampled well above the fast-mode clock rate.
  wire scl_rise = scl_s_q & ~scl_p_q; // [R1]
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire scl_high = scl_s_q & scl_p_q;
  // A data change with the clock high is never data, only a condition.
  wire cond_start = scl_high & sda_p_q & ~sda_s_q; // [R4] [R5]
  wire cond_stop = scl_high & ~sda_p_q & sda_s_q; // [R4] [R6]

  // ---------------- Link domain: protocol engine ----------------

  rtcisp_state_t st_q;
  rtcisp_state_t st_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic got_q;
  logic got_d;
  logic [DW-1:0] sh_q;
  logic [DW-1:0] sh_d;
  logic [DW-1:0] tx_q;
  logic [DW-1:0] tx_d;
  logic rw_q;
  logic rw_d;
  logic pend_q;
  logic pend_d;
  logic adrack_q;
  logic adrack_d;
  logic nack_q;
  logic nack_d;
  logic [AW-1:0] ptr_q;
  logic [AW-1:0] ptr_d;
  logic oe_q;
  logic oe_d;
  logic scl_o_q;
  logic scl_oe_q;
  logic sda_o_q;
  logic wr_tgl_q;
  logic [AW-1:0] wr_addr_q;
  logic [DW-1:0] wr_data_q;

  rtcisp_mem_if #(.AW(AW), .DW(DW)) mem_bus ();

  // Named decodes of the receive and transmit paths.
  wire rx_state = (st_q == RTCISP_ST_ADDR) || (st_q == RTCISP_ST_RXD);
  wire rx_done = rx_state & scl_fall & got_q;
  wire addr_hit = (sh_q[`RTCISP_ADDR_MSB:`RTCISP_ADDR_LSB] == SLAVE_ADDR); // [R14]
  wire dir_bit = sh_q[`RTCISP_DIR_BIT];
  wire ptr_load = (st_q == RTCISP_ST_RXD) & rx_done & pend_q; // [R16]
  wire data_store = (st_q == RTCISP_ST_RXD) & rx_done & ~pend_q; // [R17]
  wire last_bit = (cnt_q == `RTCISP_BIT_LAST);
  wire [DW-1:0] rd_byte = mem_bus.rdata;
  wire [AW-1:0] ptr_inc = ptr_q + AW'(1);

  // The store is addressed by the pointer; its read data is ready long before the next clock fall.
  assign mem_bus.raddr = ptr_q; // [R18]
  assign mem_bus.we = data_store;
  assign mem_bus.waddr = ptr_q;
  assign mem_bus.wdata = sh_q;

  rtcisp_regmem #(.AW(AW), .DW(DW)) u_regmem (
    .clk(bus_clk),
    .port(mem_bus.mem)
  );

  // Next state: conditions override everything, then each state follows clock rises and falls.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    got_d = got_q;
    sh_d = sh_q;
    tx_d = tx_q;
    rw_d = rw_q;
    pend_d = pend_q;
    adrack_d = adrack_q;
    nack_d = nack_q;
    ptr_d = ptr_q;
    oe_d = oe_q;
    if (cond_start) begin
      // A start, first or repeated, ends what went before and opens an address byte.
      st_d = RTCISP_ST_ADDR; // [R5] [R13]
      cnt_d = 3'h0;
      got_d = 1'b0;
      oe_d = 1'b0;
    end else if (cond_stop) begin
      st_d = RTCISP_ST_IDLE; // [R6]
      got_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        RTCISP_ST_ADDR, RTCISP_ST_RXD: begin
          if (scl_rise) begin
            // Sample one bit per clock pulse, MSB first.
            sh_d = {sh_q[DW-2:0], sda_s_q}; // [R7] [R8]
            cnt_d = cnt_q + 3'h1;
            got_d = last_bit;
          end else if (rx_done) begin
            got_d = 1'b0;
            if (st_q == RTCISP_ST_ADDR) begin
              if (addr_hit) begin
                st_d = RTCISP_ST_ACK; // [R14]
                oe_d = 1'b1;
                rw_d = dir_bit; // [R15]
                pend_d = (dir_bit == `RTCISP_DIR_WRITE); // [R15] [R16]
                adrack_d = 1'b1;
              end else begin
                st_d = RTCISP_ST_IGN; // [R21]
              end
            end else begin
              st_d = RTCISP_ST_ACK; // [R17]
              oe_d = 1'b1;
              adrack_d = 1'b0;
              pend_d = 1'b0;
              ptr_d = pend_q ? sh_q[AW-1:0] : ptr_inc; // [R16] [R17]
            end
          end
        end
        RTCISP_ST_ACK: begin
          if (scl_rise) begin
            got_d = 1'b1; // [R9]
          end else if (scl_fall && got_q) begin
            // The line stays low through the whole ninth high period; after its fall it is let go for a write or set to the first read bit.
            got_d = 1'b0;
            cnt_d = 3'h0;
            if (adrack_q && rw_q == `RTCISP_DIR_READ) begin
              st_d = RTCISP_ST_TXD; // [R18] [R19]
              tx_d = rd_byte;
              oe_d = ~rd_byte[`RTCISP_DATA_MSB];
            end else begin
              st_d = RTCISP_ST_RXD;
              oe_d = 1'b0;
            end
          end
        end
        RTCISP_ST_TXD: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 3'h1;
            got_d = last_bit;
          end else if (scl_fall) begin
            if (got_q) begin
              // Byte sent: release for the master's answer and move to the next register.
              got_d = 1'b0;
              st_d = RTCISP_ST_MACK;
              oe_d = 1'b0;
              ptr_d = ptr_inc; // [R20]
            end else begin
              tx_d = {tx_q[DW-2:0], 1'b0}; // [R7] [R8]
              oe_d = ~tx_q[DW-2];
            end
          end
        end
        RTCISP_ST_MACK: begin
          if (scl_rise) begin
            got_d = 1'b1;
            nack_d = sda_s_q;
          end else if (scl_fall && got_q) begin
            got_d = 1'b0;
            cnt_d = 3'h0;
            if (nack_q) begin
              // Not-acknowledge ends the read; the line stays released for the stop.
              st_d = RTCISP_ST_IGN; // [R10] [R20]
            end else begin
              st_d = RTCISP_ST_TXD; // [R20]
              tx_d = rd_byte;
              oe_d = ~rd_byte[`RTCISP_DATA_MSB];
            end
          end
        end
        RTCISP_ST_IDLE, RTCISP_ST_IGN: begin
          // Waiting for the master to open a transfer on an idle bus, or ignoring foreign traffic.
          oe_d = 1'b0; // [R3] [R21]
        end
        default: begin
          st_d = RTCISP_ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // Engine registers; the pointer is reset once and otherwise survives every transfer.
  always_ff @(posedge bus_clk) begin
    if (lrst_q) begin
      st_q <= RTCISP_ST_IDLE;
      cnt_q <= 3'h0;
      got_q <= 1'b0;
      sh_q <= '0;
      tx_q <= '0;
      rw_q <= `RTCISP_DIR_WRITE;
      pend_q <= 1'b0;
      adrack_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q <= AW'(`RTCISP_PTR_RST); // [R19]
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      got_q <= got_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      rw_q <= rw_d;
      pend_q <= pend_d;
      adrack_q <= adrack_d;
      nack_q <= nack_d;
      ptr_q <= ptr_d;
      oe_q <= oe_d;
    end
  end

  // Pin drivers: both lines only ever pulled low; the clock line is never enabled.
  always_ff @(posedge bus_clk) begin
    if (lrst_q) begin
      scl_o_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      scl_o_q <= 1'b0; // [R2] [R12]
      scl_oe_q <= 1'b0; // [R12]
      sda_o_q <= 1'b0; // [R2]
    end
  end

  assign scl_o = scl_o_q;
  assign scl_oe = scl_oe_q;
  assign sda_o = sda_o_q;
  assign sda_oe = oe_q;

  // Each stored byte is held and announced to the core clock by a toggle.
  always_ff @(posedge bus_clk) begin
    if (lrst_q) begin
      wr_tgl_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else if (data_store) begin
      wr_tgl_q <= ~wr_tgl_q;
      wr_addr_q <= ptr_q;
      wr_data_q <= sh_q;
    end
  end

  logic busy_q;
  wire busy_d = (st_d != RTCISP_ST_IDLE) && (st_d != RTCISP_ST_IGN);

  // Busy is registered here, so the core clock samples one flop and never state bits in flight.
  always_ff @(posedge bus_clk) begin
    if (lrst_q) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // ---------------- Core clock domain ----------------

  logic tgl_m_q;
  logic tgl_s_q;
  logic tgl_p_q;
  logic act_m_q;
  logic act_s_q;
  logic wr_valid_q;
  logic [AW-1:0] wr_addr_c_q;
  logic [DW-1:0] wr_data_c_q;

  // The toggle and the busy level cross on two flip-flops; address and data are quiet by then.
  wire wr_event = tgl_s_q ^ tgl_p_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      tgl_m_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_p_q <= 1'b0;
      act_m_q <= 1'b0;
      act_s_q <= 1'b0;
    end else begin
      tgl_m_q <= wr_tgl_q;
      tgl_s_q <= tgl_m_q;
      tgl_p_q <= tgl_s_q;
      act_m_q <= busy_q;
      act_s_q <= act_m_q;
    end
  end

  // One-cycle write notice to the timekeeping core with the register address and byte.
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_valid_q <= 1'b0;
      wr_addr_c_q <= '0;
      wr_data_c_q <= '0;
    end else begin
      wr_valid_q <= wr_event; // [R17]
      if (wr_event) begin
        wr_addr_c_q <= wr_addr_q;
        wr_data_c_q <= wr_data_q;
      end
    end
  end

  assign reg_wr_valid = wr_valid_q;
  assign reg_wr_addr = wr_addr_c_q;
  assign reg_wr_data = wr_data_c_q;
  assign bus_active = act_s_q;

  // ---------------- Assertions ----------------

  a_lines_open_drain: // [R2]
  // Link checks also rest while the core reset is high: the link reset flops hold no value for two link clocks.
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst) !sda_o && !scl_o && !scl_oe)
    else $error("Pin driven high or clock line enabled.");

  a_start_to_addr: // [R5]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst)
    cond_start |=> st_q == RTCISP_ST_ADDR && !sda_oe)
    else $error("Start not followed by address phase.");

  a_stop_to_idle: // [R6]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst)
    cond_stop && !cond_start |=> st_q == RTCISP_ST_IDLE)
    else $error("Stop did not end the transfer.");

  a_data_chg_low: // [R7]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst) $changed(sda_oe) && !$past(cond_start)
    |-> $past(scl_fall))
    else $error("Data line changed outside a clock fall.");

  a_addr_ack: // [R14]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst)
    st_q == RTCISP_ST_ADDR && rx_done && !cond_start && !cond_stop
    |=> (st_q == RTCISP_ST_ACK) == $past(addr_hit) && sda_oe == $past(addr_hit))
    else $error("Address acknowledge does not follow the match.");

  a_mismatch_quiet: // [R21]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst) st_q == RTCISP_ST_IGN |-> !sda_oe)
    else $error("Data line pulled while ignoring traffic.");

  a_ptr_load: // [R16]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst) ptr_load && !cond_start && !cond_stop
    |=> ptr_q == $past(sh_q[AW-1:0]) ##1 st_q == RTCISP_ST_ACK)
    else $error("Pointer byte not loaded.");

  a_ptr_incr: // [R17]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst) data_store && !cond_start && !cond_stop
    |=> ptr_q == $past(ptr_inc) && oe_q)
    else $error("Pointer not incremented after a stored byte.");

  a_read_dir: // [R15]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst) st_q == RTCISP_ST_TXD |-> rw_q && !pend_q)
    else $error("Transmitting without a read direction.");

  a_tx_msb_first: // [R8]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst)
    st_q == RTCISP_ST_TXD |-> sda_oe == ~tx_q[DW-1])
    else $error("Transmitted bit is not the byte MSB.");

  a_nack_release: // [R10]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst)
    st_q == RTCISP_ST_MACK && scl_fall && got_q && nack_q && !cond_start && !cond_stop
    |=> st_q == RTCISP_ST_IGN && !sda_oe)
    else $error("Data line not released after not-acknowledge.");

  a_ack_hold: // [R9]
  assert property (@(posedge bus_clk) disable iff (lrst_q || srst)
    st_q == RTCISP_ST_ACK && scl_rise && !cond_start && !cond_stop |-> sda_oe ##1 sda_oe)
    else $error("Acknowledge not held low over the ninth pulse.");

  a_wr_pulse: // [R17]
  assert property (@(posedge clk) disable iff (srst) reg_wr_valid |=> !reg_wr_valid)
    else $error("Write notice longer than one cycle.");

endmodule : rtcisp_top

// ### tb/rtcisp_master.sv
// Behavioural two-wire bus master that drives the slave port over open-drain lines.
`timescale 1ns/1ps
module rtcisp_master #(
  parameter int HALF = 5
) (
  input wire logic bus_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_pull,
  output logic sda_pull,
  output logic unstable
);
  // Both lines start released, so the bus is idle when the first transfer begins.
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    unstable = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge bus_clk);
  endtask : hold

  // Start or repeated start: release both lines, then pull data low while the clock is high.
  task automatic start_cond();
    sda_pull <= 1'b0;
    hold(HALF);
    scl_pull <= 1'b0;
    hold(HALF);
    sda_pull <= 1'b1;
    hold(HALF);
    scl_pull <= 1'b1;
    hold(HALF);
  endtask : start_cond

  // Stop: data goes low under a low clock, then rises while the clock is high.
  task automatic stop_cond();
    sda_pull <= 1'b1;
    hold(HALF);
    scl_pull <= 1'b0;
    hold(HALF);
    sda_pull <= 1'b0;
    hold(HALF);
  endtask : stop_cond

  // One clock pulse; data changes only one cycle after the clock has fallen, and the line
  // is sampled at both ends of the high phase to catch a change under a high clock.
  task automatic xfer_bit(input logic b, output logic seen);
    logic first;
    sda_pull <= ~b;
    hold(HALF);
    scl_pull <= 1'b0;
    hold(1);
    #1;
    first = sda_i;
    hold(HALF - 1);
    #1;
    seen = sda_i;
    if (first !== seen) unstable <= 1'b1;
    hold(1);
    scl_pull <= 1'b1;
    hold(1);
  endtask : xfer_bit

  // Byte out, MSB first, then the ninth pulse with data released for the receiver's answer.
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], s);
    xfer_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // Byte in, MSB first; the master acknowledges all but the last byte of a read.
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, s);
      d[i] = s;
    end
    xfer_bit(~ack, s);
  endtask : recv_byte
endmodule : rtcisp_master

// ### tb/tb.sv
// Self-checking testbench of the two-wire slave port driven by a behavioural bus master.
`timescale 1ns/1ps
`include "rtcisp_defs.svh"
module tb import rtcisp_pkg::*;;
  logic clk, bus_clk, srst, scl_pull, sda_pull, unstable, drove_bad;
  logic scl_o, scl_oe, sda_o, sda_oe, reg_wr_valid, bus_active;
  logic [7:0] reg_wr_addr, reg_wr_data, ptr_m;
  logic [7:0] mem_m [256];
  logic [15:0] wr_q [$];
  logic [15:0] exp_q [$];
  logic [31:0] rng_q = 32'h7649E763;
  int failures, samples_checked, cycles;
  wire scl_w = ~(scl_oe | scl_pull);
  wire sda_w = ~(sda_oe | sda_pull);

  always #2.5 clk = ~clk;
  always #24 bus_clk = ~bus_clk;

  rtcisp_top DUT (.clk(clk), .srst(srst), .bus_clk(bus_clk), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .bus_active(bus_active));
  rtcisp_master u_mst (.bus_clk(bus_clk), .scl_i(scl_w), .sda_i(sda_w), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .unstable(unstable));

  // Collects stored bytes, flags any drive high or on the clock, and cuts a hang short.
  always @(posedge clk) begin
    if (reg_wr_valid === 1'b1) wr_q.push_back({reg_wr_addr, reg_wr_data});
    if (!srst && (scl_oe === 1'b1 || scl_o === 1'b1 || sda_o === 1'b1)) drove_bad <= 1'b1;
    cycles++;
    if (cycles == 90000) begin
      failures++;
      conclude();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] addr_byte(input logic dir);
    return {`RTCISP_SLAVE_ADDR, dir};
  endfunction : addr_byte

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Write transfer: pointer byte, then n random data bytes that the model files away.
  task automatic do_write(input logic [7:0] p, input int n);
    logic ack;
    u_mst.start_cond();
    u_mst.send_byte(addr_byte(`RTCISP_DIR_WRITE), ack);
    check(ack, 1);
    u_mst.send_byte(p, ack);
    check(ack, 1);
    check(bus_active, 1);
    ptr_m = p;
    for (int i = 0; i < n; i++) begin
      rng_q = xs(rng_q);
      u_mst.send_byte(rng_q[7:0], ack);
      check(ack, 1);
      mem_m[ptr_m] = rng_q[7:0];
      exp_q.push_back({ptr_m, rng_q[7:0]});
      ptr_m++;
    end
  endtask : do_write

  // Read transfer of n bytes from the modelled pointer, not-acknowledging the last one.
  task automatic do_read(input int n);
    logic ack;
    logic [7:0] d;
    u_mst.start_cond();
    u_mst.send_byte(addr_byte(`RTCISP_DIR_READ), ack);
    check(ack, 1);
    for (int i = 0; i < n; i++) begin
      u_mst.recv_byte(i != n - 1, d);
      check(d, mem_m[ptr_m]);
      ptr_m++;
    end
    repeat (6) @(posedge bus_clk);
    #1;
    check(sda_oe, 0);
  endtask : do_read

  task automatic cmp_writes();
    check(wr_q.size(), exp_q.size());
    while (wr_q.size() > 0 && exp_q.size() > 0) check(wr_q.pop_front(), exp_q.pop_front());
    wr_q.delete();
    exp_q.delete();
  endtask : cmp_writes

  // Main sequence: wrong addresses, then random bursts read back in one or two transfers.
  initial begin
    logic ack;
    logic [6:0] wa;
    logic [7:0] p;
    int n;
    clk = 1'b0;
    bus_clk = 1'b0;
    srst = 1'b1;
    drove_bad = 1'b0;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (48) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge bus_clk);
    for (int k = 0; k < 3; k++) begin
      rng_q = xs(rng_q);
      wa = rng_q[6:0];
      if (wa == `RTCISP_SLAVE_ADDR) wa = wa ^ 7'h01;
      u_mst.start_cond();
      u_mst.send_byte({wa, rng_q[7]}, ack);
      check(ack, 0);
      u_mst.send_byte(8'hFF, ack);
      check(ack, 0);
      check(bus_active, 0);
      u_mst.stop_cond();
    end
    cmp_writes();
    for (int k = 0; k < 4; k++) begin
      rng_q = xs(rng_q);
      p = (k == 0) ? 8'hFF : rng_q[7:0];
      n = 1 + rng_q[9:8] % 3;
      do_write(p, n);
      u_mst.stop_cond();
      cmp_writes();
      do_write(p, 0);
      do_read(1);
      u_mst.stop_cond();
      if (n > 1) do_read(n - 1);
      u_mst.stop_cond();
    end
    check(unstable, 0);
    check(drove_bad, 0);
    conclude();
  end
endmodule : tb
